// ### rtl/pll_cfg_defs.svh
// field positions, reset values and constants of the pll configuration word
// included by the decoder and the bench; definitions only
`ifndef PLL_CFG_DEFS_SVH
`define PLL_CFG_DEFS_SVH
`define CFG_WORD_W          32
`define CFG_ADDR_W          4
`define CFG_OFF_WORD        4'h0
`define CFG_OFF_DECODED     4'h4
`define CFG_OFF_STATUS      4'h8
`define CFG_OFF_NVM_WRITE   4'hc
`define CFG_SYS_ODIV_LSB    16
`define CFG_USB_BYPASS_BIT  15
`define CFG_USB_IDIV_LSB    8
`define CFG_SYS_MULT_LSB    4
`define CFG_SYS_IDIV_LSB    0
`define CFG_RSVD_MASK       32'hfff8_7888
`define CFG_ERASED_WORD     32'hffff_ffff
`define CFG_NO_USB_MASK     32'hffff_78ff
`define CFG_FIELD_W         3
`define CFG_RST_ODIV        9'h100
`define CFG_RST_MULT        5'h18
`define CFG_RST_IDIV        3'h7
`define CFG_RST_UDIV        5'h0c
`endif

// ### rtl/pll_cfg_pkg.sv
// types shared by the pll configuration word decoder
// assumes the defs header is on the include path
package pll_cfg_pkg;
  typedef logic [2:0] code3_t;
  typedef logic [8:0] odiv_t;
  typedef logic [4:0] factor_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LOAD  = 3'b010,
    ST_READY = 3'b100
  } load_state_t;
endpackage

// ### rtl/pll_div_decode.sv
// combinational code-to-factor decode for the pll configuration fields
// pure logic; the caller registers the results
`timescale 1ns/1ps
module pll_div_decode
  import pll_cfg_pkg::*;
(
  input  wire code3_t  odiv_code,
  input  wire code3_t  idiv_code,
  input  wire code3_t  mult_code,
  output odiv_t        sys_out_div,
  output factor_t      usb_in_div,
  output factor_t      sys_mult
);
  function automatic odiv_t out_div(input code3_t c);
    if (c == 3'h7) begin
      out_div = 9'h100;
    end else begin
      out_div = odiv_t'(9'h001 << c);
    end
  endfunction

  function automatic factor_t usb_div(input code3_t c);
    unique case (c)
      3'h6:    usb_div = 5'h0a;
      3'h7:    usb_div = 5'h0c;
      default: usb_div = factor_t'({2'h0, c} + 5'h01);
    endcase
  endfunction

  function automatic factor_t mult(input code3_t c);
    unique case (c)
      3'h6:    mult = 5'h15;
      3'h7:    mult = 5'h18;
      default: mult = factor_t'({2'h0, c} + 5'h0f);
    endcase
  endfunction

  assign sys_out_div = out_div(odiv_code);
  assign usb_in_div  = usb_div(idiv_code);
  assign sys_mult    = mult(mult_code);
endmodule

// ### rtl/pll_config_word_decoder.sv
// pll configuration word: power-on latch, decode, register port
// assumes cfg_nvm_word is stable while resetn is low and shortly after
// Overview of operation
// - system pll output divisor is 2 to the code in bits 18:16, code 7 giving 256.
// - bit 15 low enables the usb pll, high disables and bypasses it.
// - bits 10:8 select usb pll input division of 1,2,3,4,5,6,10 or 12.
// - bits 6:4 select system pll multiplication of 15 to 20, 21 or 24.
// - usb fields exist only on variants with the usb function.
`timescale 1ns/1ps
`include "pll_cfg_defs.svh"
module pll_config_word_decoder
  import pll_cfg_pkg::*;
#(
  parameter bit HAS_USB = 1'b1
)(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [`CFG_WORD_W-1:0]   cfg_nvm_word,
  input  wire logic [`CFG_ADDR_W-1:0]   reg_addr,
  input  wire logic [`CFG_WORD_W-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [`CFG_WORD_W-1:0]        reg_rdata,
  output logic                          cfg_valid,
  output logic [8:0]                    sys_pll_out_div,
  output logic [4:0]                    sys_pll_mult,
  output logic [2:0]                    sys_pll_in_div,
  output logic [4:0]                    usb_pll_in_div,
  output logic                          usb_pll_bypass,
  output logic                          usb_pll_enable
);
  // field slices below assume a 32-bit word of 3-bit codes
  if (`CFG_WORD_W != 32) begin : g_bad_word_w
    $error("configuration word must be 32 bits wide");
  end
  if (`CFG_SYS_ODIV_LSB + `CFG_FIELD_W > `CFG_WORD_W) begin : g_bad_field_pos
    $error("output divisor field lies outside the configuration word");
  end

  load_state_t                 state_q;
  logic [`CFG_WORD_W-1:0]      word_q;
  logic                        rsvd_err_q;
  logic                        wr_ignored_q;
  logic [`CFG_WORD_W-1:0]      word_eff;
  odiv_t                       odiv_w;
  factor_t                     udiv_w;
  factor_t                     mult_w;
  logic                        load_now;
  logic [`CFG_WORD_W-1:0]      rsvd_low;
  logic [`CFG_WORD_W-1:0]      decoded_w;
  logic [`CFG_WORD_W-1:0]      status_w;
  localparam logic [`CFG_WORD_W-1:0] RSVD_MASK = `CFG_RSVD_MASK;

  // non-usb variants see the usb fields as reserved ones
  assign word_eff = HAS_USB ? word_q : (word_q | ~`CFG_NO_USB_MASK);

  pll_div_decode u_dec (
    .odiv_code   (word_eff[`CFG_SYS_ODIV_LSB +: 3]),
    .idiv_code   (word_eff[`CFG_USB_IDIV_LSB +: 3]),
    .mult_code   (word_eff[`CFG_SYS_MULT_LSB +: 3]),
    .sys_out_div (odiv_w),
    .usb_in_div  (udiv_w),
    .sys_mult    (mult_w)
  );

  // power-on load: a strap-like capture one clock after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  state_q <= ST_LOAD;
        ST_LOAD:  state_q <= ST_READY;
        ST_READY: state_q <= ST_READY;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_q <= `CFG_ERASED_WORD;
    end else if (state_q == ST_IDLE) begin
      word_q <= cfg_nvm_word;
    end
  end

  assign load_now = (state_q == ST_LOAD);

  // one check per word bit, so the mask alone says which bits are reserved
  for (genvar i = 0; i < `CFG_WORD_W; i++) begin : g_rsvd
    assign rsvd_low[i] = RSVD_MASK[i] & ~word_q[i];
  end

  // a programmer that left a reserved bit at zero is flagged, not corrected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsvd_err_q <= 1'b0;
    end else if (load_now) begin
      rsvd_err_q <= |rsvd_low;
    end
  end

  // decoded defaults, held until the next power-on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_valid <= 1'b0;
    end else if (load_now) begin
      cfg_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_pll_out_div <= `CFG_RST_ODIV;
    end else if (load_now) begin
      sys_pll_out_div <= odiv_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_pll_mult <= `CFG_RST_MULT;
    end else if (load_now) begin
      sys_pll_mult <= mult_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_pll_in_div <= `CFG_RST_IDIV;
    end else if (load_now) begin
      sys_pll_in_div <= word_eff[`CFG_SYS_IDIV_LSB +: 3];
    end
  end

  // a variant without the usb function has no usb pll: its bypass and enable
  // keep the disabled setting and its divider loads one, whatever the word holds
  if (HAS_USB) begin : g_usb
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_in_div <= `CFG_RST_UDIV;
      end else if (load_now) begin
        usb_pll_in_div <= udiv_w;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_bypass <= 1'b1;
      end else if (load_now) begin
        usb_pll_bypass <= word_eff[`CFG_USB_BYPASS_BIT];
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_enable <= 1'b0;
      end else if (load_now) begin
        usb_pll_enable <= ~word_eff[`CFG_USB_BYPASS_BIT];
      end
    end
  end else begin : g_no_usb
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_in_div <= `CFG_RST_UDIV;
      end else if (load_now) begin
        usb_pll_in_div <= 5'h01;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_bypass <= 1'b1;
      end else if (load_now) begin
        usb_pll_bypass <= 1'b1;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        usb_pll_enable <= 1'b0;
      end else if (load_now) begin
        usb_pll_enable <= 1'b0;
      end
    end
  end

  // word is read-only; writes are dropped and remembered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ignored_q <= 1'b0;
    end else if (reg_wr) begin
      wr_ignored_q <= 1'b1;
    end else if (reg_rd && reg_addr == `CFG_OFF_STATUS) begin
      wr_ignored_q <= 1'b0;
    end
  end

  // register read decode; unmapped offsets read as zero
  function automatic logic [`CFG_WORD_W-1:0] read_mux(
    input logic [`CFG_ADDR_W-1:0] a,
    input logic [`CFG_WORD_W-1:0] word,
    input logic [`CFG_WORD_W-1:0] dec,
    input logic [`CFG_WORD_W-1:0] stat
  );
    unique case (a)
      `CFG_OFF_WORD:    read_mux = word;
      `CFG_OFF_DECODED: read_mux = dec;
      `CFG_OFF_STATUS:  read_mux = stat;
      default:          read_mux = '0;
    endcase
  endfunction

  assign decoded_w = {2'h0, usb_pll_bypass, usb_pll_in_div, sys_pll_in_div, sys_pll_mult,
                      3'h0, sys_pll_out_div, 4'h0};
  // a write beside a status read still shows, so no ignored write is lost
  assign status_w  = {28'h0, HAS_USB, wr_ignored_q | reg_wr, rsvd_err_q, cfg_valid};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_mux(reg_addr, word_eff, decoded_w, status_w);
    end else begin
      reg_rdata <= '0;
    end
  end

  logic unused_wdata;
  assign unused_wdata = ^reg_wdata;
endmodule

// ### tb/pll_cfg_sva.sv
// assertions on the decoded pll configuration outputs
// assumes cfg_nvm_word only changes while resetn is low
`timescale 1ns/1ps
module pll_cfg_chk #(
  parameter bit HAS_USB = 1'b1
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [31:0] cfg_nvm_word,
  input wire logic        cfg_valid,
  input wire logic [8:0]  sys_pll_out_div,
  input wire logic [4:0]  sys_pll_mult,
  input wire logic [2:0]  sys_pll_in_div,
  input wire logic [4:0]  usb_pll_in_div,
  input wire logic        usb_pll_bypass,
  input wire logic        usb_pll_enable
);
  logic [31:0] w;
  logic [2:0]  u;
  assign w = cfg_nvm_word;
  // variants without usb hold the usb divider at one
  assign u = w[10:8];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_load;
    !cfg_valid ##2 cfg_valid;
  endsequence
  AST_ODIV: assert property (cfg_valid |->
    sys_pll_out_div == (w[18:16] == 3'h7 ? 9'h100 : 9'h001 << w[18:16])) else $error("odiv");
  AST_USB_EN: assert property (cfg_valid |->
    usb_pll_bypass == (w[15] | !HAS_USB) && usb_pll_enable == !usb_pll_bypass) else $error("usb");
  AST_UDIV: assert property (cfg_valid |-> usb_pll_in_div == (!HAS_USB ? 5'h01 :
    u == 3'h7 ? 5'h0c : u == 3'h6 ? 5'h0a : {2'h0, u} + 5'h01)) else $error("udiv");
  AST_MULT: assert property (cfg_valid |->
    sys_pll_mult == (w[6:4] == 3'h7 ? 5'h18 : {2'h0, w[6:4]} + 5'h0f)) else $error("mult");
  AST_IDIV: assert property (cfg_valid |-> sys_pll_in_div == w[2:0]) else $error("idiv");
  AST_LOAD: assert property ($rose(resetn) |-> s_load) else $error("load");
endmodule
bind pll_config_word_decoder pll_cfg_chk #(.HAS_USB(HAS_USB)) pll_cfg_chk_i (.clk, .resetn,
  .cfg_nvm_word, .cfg_valid, .sys_pll_out_div, .sys_pll_mult, .sys_pll_in_div,
  .usb_pll_in_div, .usb_pll_bypass, .usb_pll_enable);

// ### tb/tb.sv
// bench for the pll configuration word decoder
// one nvm word per test, loaded through a reset
`timescale 1ns/1ps
`include "pll_cfg_defs.svh"
module tb
  import pll_cfg_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cfg_valid, usb_pll_bypass, usb_pll_enable;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] cfg_nvm_word = 32'hffff_ffff, reg_wdata = 32'h0, reg_rdata, d;
  logic [8:0]  sys_pll_out_div;
  logic [4:0]  sys_pll_mult, usb_pll_in_div;
  logic [2:0]  sys_pll_in_div;
  logic [31:0] reg_rdata_nu, d_nu;
  int          errors = 0, check_count = 0;
  pll_config_word_decoder pll_config_word_decoder_i (.clk, .resetn, .cfg_nvm_word, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_valid, .sys_pll_out_div, .sys_pll_mult,
    .sys_pll_in_div, .usb_pll_in_div, .usb_pll_bypass, .usb_pll_enable);
  // variant without the usb function, seen through its register port and the checker
  pll_config_word_decoder #(.HAS_USB(1'b0)) pll_config_word_decoder_nu_i (.clk, .resetn,
    .cfg_nvm_word, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(reg_rdata_nu),
    .cfg_valid(), .sys_pll_out_div(), .sys_pll_mult(), .sys_pll_in_div(),
    .usb_pll_in_div(), .usb_pll_bypass(), .usb_pll_enable());
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    d_nu = reg_rdata_nu;
    @(posedge clk);
  endtask
  task automatic run(input code3_t c);
    logic [31:0] w;
    logic [8:0]  od;
    logic [4:0]  mu, ud;
    w = `CFG_RSVD_MASK | {13'h0, c, c[0], 4'h0, c, 1'b0, c, 1'b0, c};
    od = (c == 3'h7) ? 9'h100 : 9'h001 << c;
    mu = (c == 3'h7) ? 5'h18 : {2'h0, c} + 5'h0f;
    ud = (c == 3'h7) ? 5'h0c : (c == 3'h6) ? 5'h0a : {2'h0, c} + 5'h01;
    resetn <= 1'b0;
    cfg_nvm_word <= w;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // a read at the first edge after release still sees the erased word
    rd(`CFG_OFF_WORD);
    chk("erased", `CFG_ERASED_WORD, d);
    chk("erased_nu", `CFG_ERASED_WORD, d_nu);
    rd(`CFG_OFF_WORD);
    chk("word", w, d);
    chk("word_nu", w | 32'h0000_8700, d_nu);
    #1 chk("valid", 32'h1, {31'h0, cfg_valid});
    chk("odiv", {23'h0, od}, {23'h0, sys_pll_out_div});
    chk("usb", {30'h0, c[0], ~c[0]}, {30'h0, usb_pll_bypass, usb_pll_enable});
    chk("udiv", {27'h0, ud}, {27'h0, usb_pll_in_div});
    chk("mult", {27'h0, mu}, {27'h0, sys_pll_mult});
    chk("idiv", {29'h0, c}, {29'h0, sys_pll_in_div});
    @(posedge clk);
    rd(`CFG_OFF_DECODED);
    chk("decoded", {2'h0, c[0], ud, c, mu, 3'h0, od, 4'h0}, d);
    chk("decoded_nu", {2'h0, 1'b1, 5'h01, c, mu, 3'h0, od, 4'h0}, d_nu);
    reg_addr <= `CFG_OFF_WORD;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd(`CFG_OFF_STATUS);
    chk("status", 32'hd, d);
    chk("status_nu", 32'h5, d_nu);
    rd(`CFG_OFF_STATUS);
    chk("status2", 32'h9, d);
    chk("status2_nu", 32'h1, d_nu);
    rd(`CFG_OFF_WORD);
    chk("kept", w, d);
    rd(4'hc);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    for (int c = 0; c < 8; c++) begin
      run(c[2:0]);
      $display("test code %0d done", c);
    end
    print_verdict();
  end
  // eight tests need about 210 cycles
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule
